// file: hw/i2c_slave_status_and_data.sv
// two-wire slave engine with status flags, data registers and wishbone slave
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_status_and_data #(
  parameter int FIFO_DEPTH = i2c_slv_pkg::FIFO_DEPTH
) (
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // two-wire pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  // request line
  output logic irq_o
);
  import i2c_slv_pkg::*;

  // pin synchronisers
  logic [2:0] scl_s, sda_s;
  logic scl_f_r, scl_f_nxt, sda_f_r, sda_f_nxt;
  logic scl_rise, scl_fall, ev_start, ev_stop;
  // link engine
  link_state_type st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic rd_r, rd_nxt, gcp_r, gcp_nxt, pull_r, pull_nxt, rel_r, rel_nxt;
  logic ev_nomatch, ev_txq, ev_ufl, ev_et, ev_gc, ev_ackd, ev_nack, ev_soft;
  logic [1:0] gck_ev;
  logic rx_push, tx_pop;
  logic [7:0] rx_pdata;
  // registers and flags
  logic [7:0] ctrl_r, ctrl_nxt, alt_r, alt_nxt;
  id_arr_type id_r, id_nxt;
  logic [1:0] gck_r, gck_nxt;
  logic gc_r, gc_nxt, busy_r, busy_nxt, nack_r, nack_nxt, ovf_r, ovf_nxt;
  logic rxq_r, rxq_nxt, txq_r, txq_nxt, ufl_r, ufl_nxt, et_r, et_nxt;
  logic etd_r, etd_nxt, irq_r, irq_nxt, ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic [15:0] status_v;
  logic acc, rd_rx, rd_st, wr_tx, wr_ctrl, gc_clr, flush;
  // fifos
  logic rx_full, rx_empty, tx_full, tx_empty;
  logic [7:0] rx_dout, tx_dout;

  function automatic logic addr_hit(input id_arr_type ids, input logic [6:0] a);
    addr_hit = 1'b0;
    for (int i = 0; i < NUM_IDS; i++) begin
      if (ids[i][7:1] == a) begin
        addr_hit = 1'b1;
      end
    end
  endfunction

  // a level counts once second and third stage agree
  always_comb begin
    scl_f_nxt = (scl_s[1] == scl_s[2]) ? scl_s[2] : scl_f_r;
    sda_f_nxt = (sda_s[1] == sda_s[2]) ? sda_s[2] : sda_f_r;
  end
  assign scl_rise = scl_f_nxt && !scl_f_r;
  assign scl_fall = !scl_f_nxt && scl_f_r;
  assign ev_start = scl_f_r && scl_f_nxt && sda_f_r && !sda_f_nxt;
  assign ev_stop = scl_f_r && scl_f_nxt && !sda_f_r && sda_f_nxt;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
    end else begin
      scl_s <= {scl_s[1:0], scl_i};
      sda_s <= {sda_s[1:0], sda_i};
      scl_f_r <= scl_f_nxt;
      sda_f_r <= sda_f_nxt;
    end
  end

  // link engine
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    rd_nxt = rd_r;
    gcp_nxt = gcp_r;
    pull_nxt = pull_r;
    {ev_nomatch, ev_txq, ev_ufl, ev_et, ev_gc, ev_ackd, ev_nack, ev_soft} = '0;
    gck_ev = GC_NONE;
    rx_push = 1'b0;
    rx_pdata = sh_r;
    tx_pop = 1'b0;
    if (!ctrl_r[CT_ENABLE]) begin
      st_nxt = IDLE_ST;
      pull_nxt = 1'b0;
    end else if (ev_start) begin
      st_nxt = ADDR_ST;
      cnt_nxt = '0;
      gcp_nxt = 1'b0;
      pull_nxt = 1'b0;
    end else if (ev_stop) begin
      st_nxt = IDLE_ST;
      pull_nxt = 1'b0;
    end else begin
      case (st_r)
        ADDR_ST, RXD_ST: begin
          if (scl_rise) begin
            sh_nxt = {sh_r[6:0], sda_f_r};
            cnt_nxt = 4'(cnt_r + 4'h1);
            if (st_r == ADDR_ST && cnt_r == LAST_BIT && addr_hit(id_r, sh_r[6:0])) begin
              ev_ufl = sda_f_r && tx_empty;
              ev_txq = sda_f_r && ctrl_r[CT_ETEN];
              ev_et = !sda_f_r && ctrl_r[CT_ETEN];
            end
          end else if (scl_fall && cnt_r == BYTE_BITS) begin
            cnt_nxt = '0;
            ev_ackd = 1'b1;
            if (st_r == ADDR_ST) begin
              gcp_nxt = ctrl_r[CT_GC_EN] && sh_r[7:1] == GC_ADDR && !sh_r[0];
              rd_nxt = sh_r[0];
              if (!gcp_nxt && !addr_hit(id_r, sh_r[7:1])) begin
                ev_nomatch = 1'b1;
                ev_ackd = 1'b0;
                st_nxt = IDLE_ST;
              end else begin
                ev_nack = ctrl_r[CT_NACK_EN] || (sh_r[0] && tx_empty);
                ev_txq = sh_r[0] && !ctrl_r[CT_ETEN];
                st_nxt = ev_nack ? IDLE_ST : AACK_ST;
              end
            end else begin
              ev_nack = ctrl_r[CT_NACK_EN];
              st_nxt = ev_nack ? IDLE_ST : RACK_ST;
              if (gcp_r) begin
                gcp_nxt = 1'b0;
                ev_gc = 1'b1;
                if (sh_r == GC_CMD_RST) begin
                  gck_ev = GC_RST_PROG;
                  ev_soft = 1'b1;
                end else if (sh_r == GC_CMD_PROG) begin
                  gck_ev = GC_PROG;
                end else if (sh_r[0] && ctrl_r[CT_HWGC_EN]) begin
                  gck_ev = GC_ALT;
                  rx_push = 1'b1;
                end
              end else begin
                rx_push = 1'b1;
              end
            end
            pull_nxt = !ev_nack && !ev_nomatch;
          end
        end
        AACK_ST, RACK_ST: begin
          if (scl_fall) begin
            cnt_nxt = '0;
            st_nxt = RXD_ST;
            pull_nxt = 1'b0;
            if (st_r == AACK_ST && rd_r) begin
              tx_pop = 1'b1;
              sh_nxt = tx_dout;
              pull_nxt = !tx_dout[7];
              cnt_nxt = 4'h1;
              st_nxt = TXD_ST;
            end
          end
        end
        TXD_ST: begin
          if (scl_fall) begin
            if (cnt_r == BYTE_BITS) begin
              pull_nxt = 1'b0;
              st_nxt = TACK_ST;
            end else begin
              pull_nxt = !sh_r[6];
              sh_nxt = {sh_r[6:0], 1'b0};
              cnt_nxt = 4'(cnt_r + 4'h1);
            end
          end
        end
        TACK_ST: begin
          if (scl_rise) begin
            rd_nxt = !sda_f_r;
          end else if (scl_fall) begin
            st_nxt = IDLE_ST;
            if (rd_r && !tx_empty) begin
              tx_pop = 1'b1;
              sh_nxt = tx_dout;
              pull_nxt = !tx_dout[7];
              cnt_nxt = 4'h1;
              st_nxt = TXD_ST;
            end
          end
        end
        default: begin
          st_nxt = IDLE_ST;
          pull_nxt = 1'b0;
        end
      endcase
    end
    rel_nxt = !pull_nxt;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= IDLE_ST;
      cnt_r <= '0;
      sh_r <= BYTE_RESET;
      rd_r <= 1'b0;
      gcp_r <= 1'b0;
      pull_r <= 1'b0;
      rel_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      rd_r <= rd_nxt;
      gcp_r <= gcp_nxt;
      pull_r <= pull_nxt;
      rel_r <= rel_nxt;
    end
  end
  // open drain: only ever drives low
  assign sda_o = rel_r;
  assign sda_oe_n_o = rel_r;

  i2c_byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) rx_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .flush_i(flush),
    .push_i(rx_push),
    .push_data_i(rx_pdata),
    .full_o(rx_full),
    .pop_i(rd_rx),
    .pop_data_o(rx_dout),
    .empty_o(rx_empty)
  );

  i2c_byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) tx_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .flush_i(flush),
    .push_i(wr_tx),
    .push_data_i(wb_dat_i[7:0]),
    .full_o(tx_full),
    .pop_i(tx_pop),
    .pop_data_o(tx_dout),
    .empty_o(tx_empty)
  );

  // bus decode
  assign acc = wb_cyc_i && wb_stb_i && !ack_r;
  assign rd_rx = acc && !wb_we_i && wb_adr_i == RX_DATA_ADR;
  assign rd_st = acc && !wb_we_i && wb_adr_i == STATUS_ADR;
  assign wr_tx = acc && wb_we_i && wb_sel_i[0] && wb_adr_i == TX_DATA_ADR;
  assign wr_ctrl = acc && wb_we_i && wb_sel_i[0] && wb_adr_i == CONTROL_ADR;
  assign gc_clr = wr_ctrl && wb_dat_i[CT_GC_CLEAR];
  assign flush = ev_soft;
  assign status_v = {6'h00, gck_r, gc_r, busy_r, nack_r, ovf_r, rxq_r, txq_r, ufl_r, et_r};

  // registers, flags and bus answer
  always_comb begin
    ctrl_nxt = ctrl_r;
    alt_nxt = alt_r;
    id_nxt = id_r;
    ack_nxt = acc;
    dat_nxt = '0;
    if (acc && !wb_we_i) begin
      // empty fifo reads as the reset value, never stale storage
      if (wb_adr_i == RX_DATA_ADR) dat_nxt[7:0] = rx_empty ? BYTE_RESET : rx_dout;
      if (wb_adr_i == STATUS_ADR) dat_nxt[15:0] = status_v;
      if (wb_adr_i == CONTROL_ADR) dat_nxt[7:0] = {1'b0, ctrl_r[6:0]};
      if (wb_adr_i == ALT_ID_ADR) dat_nxt[7:0] = alt_r;
      for (int i = 0; i < NUM_IDS; i++) begin
        if (wb_adr_i == 32'(ID0_ADR + ID_STEP * 32'(i))) dat_nxt[7:0] = id_r[i];
      end
    end
    if (acc && wb_we_i && wb_sel_i[0]) begin
      if (wr_ctrl) ctrl_nxt = {1'b0, wb_dat_i[6:0]};
      if (wb_adr_i == ALT_ID_ADR) alt_nxt = wb_dat_i[7:0];
      for (int i = 0; i < NUM_IDS; i++) begin
        if (wb_adr_i == 32'(ID0_ADR + ID_STEP * 32'(i))) id_nxt[i] = wb_dat_i[7:0];
      end
    end
    gc_nxt = gc_clr ? 1'b0 : gc_r;
    gck_nxt = gc_clr ? GC_NONE : gck_r;
    if (ev_gc) begin
      gc_nxt = 1'b1;
      gck_nxt = gck_ev;
    end
    busy_nxt = ev_start || (busy_r && !ev_stop && !ev_nomatch);
    nack_nxt = ev_ackd ? ev_nack : nack_r;
    ovf_nxt = rx_push ? rx_full : ovf_r;
    rxq_nxt = !rx_empty;
    txq_nxt = ev_txq || (txq_r && !ev_start && !ev_stop && !wr_tx);
    ufl_nxt = ev_ufl || (ufl_r && !ev_start && !wr_tx);
    etd_nxt = etd_r && !ev_start;
    et_nxt = et_r && !rd_st;
    if (busy_r && !etd_nxt && (ev_et || (!ctrl_r[CT_ETEN] && tx_empty))) begin
      et_nxt = 1'b1;
      etd_nxt = 1'b1;
    end
    irq_nxt = (rxq_r && ctrl_r[CT_RX_IE]) || (txq_r && ctrl_r[CT_TX_IE]);
    if (ev_soft) begin
      ctrl_nxt = CTRL_RESET;
      alt_nxt = BYTE_RESET;
      id_nxt = '{default: BYTE_RESET};
      {nack_nxt, ovf_nxt, txq_nxt, ufl_nxt, et_nxt, irq_nxt} = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= CTRL_RESET;
      alt_r <= BYTE_RESET;
      id_r <= '{default: BYTE_RESET};
      {gc_r, busy_r, nack_r, ovf_r, rxq_r, txq_r, ufl_r, et_r, etd_r} <= '0;
      gck_r <= GC_NONE;
      irq_r <= 1'b0;
      ack_r <= 1'b0;
      dat_r <= '0;
    end else begin
      ctrl_r <= ctrl_nxt;
      alt_r <= alt_nxt;
      id_r <= id_nxt;
      {gc_r, busy_r, nack_r, ovf_r, rxq_r} <= {gc_nxt, busy_nxt, nack_nxt, ovf_nxt, rxq_nxt};
      {txq_r, ufl_r, et_r, etd_r} <= {txq_nxt, ufl_nxt, et_nxt, etd_nxt};
      gck_r <= gck_nxt;
      irq_r <= irq_nxt;
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign irq_o = irq_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_gc_byte;
    st_r == RXD_ST && gcp_r && scl_fall && cnt_r == BYTE_BITS && ctrl_r[CT_ENABLE];
  endsequence
  sequence s_read_addr;
    st_r == ADDR_ST && scl_fall && cnt_r == BYTE_BITS && sh_r[0] && ctrl_r[CT_ENABLE];
  endsequence

  property p_gc_clear;
    gc_clr && !ev_gc |=> !gc_r && gck_r == GC_NONE;
  endproperty
  a_gc_clear: assert property (p_gc_clear) else $error("gc clear ignored");
  property p_gc_set;
    s_gc_byte |=> gc_r ##1 (gc_r || $past(gc_clr));
  endproperty
  a_gc_set: assert property (p_gc_set) else $error("gc flag not set");
  property p_gc_reset;
    s_gc_byte and sh_r == GC_CMD_RST |=> ctrl_r == CTRL_RESET && gck_r == GC_RST_PROG;
  endproperty
  a_gc_reset: assert property (p_gc_reset) else $error("gc reset missed");
  property p_busy;
    ev_start |=> busy_r;
  endproperty
  a_busy: assert property (p_busy) else $error("busy not set on start");
  property p_idle;
    ev_stop |=> !busy_r;
  endproperty
  a_idle: assert property (p_idle) else $error("busy not cleared on stop");
  property p_ovf;
    rx_push && rx_full |=> ovf_r;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow missed");
  property p_rxq;
    rx_push && !flush |=> ##1 rxq_r;
  endproperty
  a_rxq: assert property (p_rxq) else $error("rx request missing");
  property p_txq;
    s_read_addr and (!ctrl_r[CT_ETEN] && addr_hit(id_r, sh_r[7:1])) |=> txq_r;
  endproperty
  a_txq: assert property (p_txq) else $error("tx request missing");
  property p_et_rd;
    et_r && rd_st && !ev_et |=> !et_r || (busy_r && !ctrl_r[CT_ETEN]);
  endproperty
  a_et_rd: assert property (p_et_rd) else $error("early flag kept");
  property p_nack;
    s_read_addr and (tx_empty && addr_hit(id_r, sh_r[7:1])) |=> nack_r && !pull_r;
  endproperty
  a_nack: assert property (p_nack) else $error("nack not flagged");
endmodule
`default_nettype wire

// file: hw/i2c_slv_pkg.sv
// constants and types shared by the slave status and data block
package i2c_slv_pkg;
  localparam int NUM_IDS = 4;
  localparam int FIFO_DEPTH = 2;
  // wishbone byte addresses
  localparam logic [31:0] RX_DATA_ADR = 32'hffff0830;
  localparam logic [31:0] TX_DATA_ADR = 32'hffff0834;
  localparam logic [31:0] ALT_ID_ADR = 32'hffff0838;
  localparam logic [31:0] ID0_ADR = 32'hffff083c;
  localparam logic [31:0] ID_STEP = 32'h00000004;
  localparam logic [31:0] STATUS_ADR = 32'hffff0850;
  localparam logic [31:0] CONTROL_ADR = 32'hffff0854;
  // control register bits
  localparam int CT_ENABLE = 0;
  localparam int CT_GC_EN = 1;
  localparam int CT_ETEN = 2;
  localparam int CT_HWGC_EN = 3;
  localparam int CT_NACK_EN = 4;
  localparam int CT_RX_IE = 5;
  localparam int CT_TX_IE = 6;
  localparam int CT_GC_CLEAR = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  // status register bits
  localparam int ST_ETSTA = 0;
  localparam int ST_UFL = 1;
  localparam int ST_TXQ = 2;
  localparam int ST_RXQ = 3;
  localparam int ST_OVF = 4;
  localparam int ST_NACK = 5;
  localparam int ST_BUSY = 6;
  localparam int ST_GC = 7;
  localparam int ST_GCK = 8;
  // general call kinds
  localparam logic [1:0] GC_NONE = 2'h0;
  localparam logic [1:0] GC_RST_PROG = 2'h1;
  localparam logic [1:0] GC_PROG = 2'h2;
  localparam logic [1:0] GC_ALT = 2'h3;
  localparam logic [6:0] GC_ADDR = 7'h00;
  localparam logic [7:0] GC_CMD_RST = 8'h06;
  localparam logic [7:0] GC_CMD_PROG = 8'h04;
  // bit counter marks
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  typedef logic [7:0] id_arr_type [NUM_IDS];
  typedef enum logic [6:0] {
    IDLE_ST = 7'h01,
    ADDR_ST = 7'h02,
    AACK_ST = 7'h04,
    RXD_ST = 7'h08,
    RACK_ST = 7'h10,
    TXD_ST = 7'h20,
    TACK_ST = 7'h40
  } link_state_type;
endpackage

// file: hw/i2c_byte_fifo.sv
// small byte fifo with flush, used for slave receive and transmit
`timescale 1ns/1ps
`default_nettype none
module i2c_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // system
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic flush_i,
  // fill side
  input wire logic push_i,
  input wire logic [WIDTH-1:0] push_data_i,
  output logic full_o,
  // drain side
  input wire logic pop_i,
  output logic [WIDTH-1:0] pop_data_o,
  output logic empty_o
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic do_push, do_pop;

  function automatic logic [PW-1:0] step(input logic [PW-1:0] p);
    step = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  assign full_o = (cnt_r == CW'(DEPTH));
  assign empty_o = (cnt_r == '0);
  assign pop_data_o = mem[rp_r];

  always_comb begin
    do_push = push_i && !full_o && !flush_i;
    do_pop = pop_i && !empty_o && !flush_i;
    wp_nxt = do_push ? step(wp_r) : wp_r;
    rp_nxt = do_pop ? step(rp_r) : rp_r;
    cnt_nxt = CW'(cnt_r + CW'(do_push) - CW'(do_pop));
    if (flush_i) begin
      wp_nxt = '0;
      rp_nxt = '0;
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
    if (do_push) begin
      mem[wp_r] <= push_data_i;
    end
  end
endmodule
`default_nettype wire

// file: tb/i2c_master_model.sv
// behavioural two-wire bus master facing the slave block
`timescale 1ns/1ps
`default_nettype none
module i2c_master_model (
  // system
  input wire logic clk_i,
  // bus
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic wait_c(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // 20 clocks per bit, a 160 ns link period; clock stands still between frames
  task automatic bit_io(input logic b, output logic seen);
    sda_o <= b;
    wait_c(5);
    scl_o <= 1'b1;
    wait_c(5);
    seen = sda_i;
    wait_c(5);
    scl_o <= 1'b0;
    wait_c(5);
  endtask
  task automatic start_cond();
    sda_o <= 1'b1;
    scl_o <= 1'b1;
    wait_c(5);
    sda_o <= 1'b0;
    wait_c(5);
    scl_o <= 1'b0;
    wait_c(5);
  endtask
  task automatic stop_cond();
    sda_o <= 1'b0;
    wait_c(5);
    scl_o <= 1'b1;
    wait_c(5);
    sda_o <= 1'b1;
    wait_c(10);
  endtask
  // msb first, then the ninth clock for the slave's acknowledge
  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  task automatic read_byte(input logic ack_it, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(~ack_it, s);
  endtask
endmodule
`default_nettype wire

// file: tb/tb.sv
// self-checking bench for the slave status and data block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import i2c_slv_pkg::*;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, d;
  logic [3:0] wb_sel_i;
  logic sda_oe_n_o, sda_out, irq_o, scl_line, m_sda, sda_line, ack;
  logic [7:0] b;
  int fail_count, checks_done, cycles;
  // pulled-up line: low if either party pulls it
  assign sda_line = m_sda & (sda_oe_n_o | sda_out);
  i2c_slave_status_and_data u_i2c_slave_status_and_data (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .scl_i(scl_line), .sda_i(sda_line), .sda_o(sda_out), .sda_oe_n_o(sda_oe_n_o),
    .irq_o(irq_o));
  i2c_master_model u_i2c_master_model (.clk_i(clk_i), .sda_i(sda_line), .scl_o(scl_line), .sda_o(m_sda));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fail_count++;
      $display("Error timeout expected finish seen hang");
      final_report();
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // classic cycle: hold until ack is seen high at a rising edge
  task automatic wb(input logic we, input logic [31:0] adr, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    wb_sel_i <= 4'h1;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] adr, input logic [7:0] v);
    logic [31:0] dummy;
    wb(1'b1, adr, {24'h0, v}, dummy);
  endtask
  task automatic gcall(input logic [7:0] cmd);
    u_i2c_master_model.start_cond();
    u_i2c_master_model.write_byte({GC_ADDR, 1'b0}, ack);
    u_i2c_master_model.write_byte(cmd, ack);
    u_i2c_master_model.stop_cond();
  endtask
  task automatic test_reset();
    wb(1'b0, STATUS_ADR, 32'h0, d);
    check("status", d, 32'h0);
    wr(RX_DATA_ADR, 8'h77);
    wb(1'b0, RX_DATA_ADR, 32'h0, d);
    check("rx_data", d, {24'h0, BYTE_RESET});
    wb(1'b0, TX_DATA_ADR, 32'h0, d);
    check("tx_data", d, {24'h0, BYTE_RESET});
    wb(1'b0, 32'hffff0900, 32'h0, d);
    check("unmapped", d, 32'h0);
    $display("test reset done");
  endtask
  task automatic test_rx();
    wr(ID0_ADR, 8'ha0);
    wr(CONTROL_ADR, 8'h2b);
    u_i2c_master_model.start_cond();
    u_i2c_master_model.write_byte(8'ha0, ack);
    check("addr_ack", ack, 1'b1);
    wb(1'b0, STATUS_ADR, 32'h0, d);
    check("busy", d[ST_BUSY], 1'b1);
    u_i2c_master_model.write_byte(8'h11, ack);
    u_i2c_master_model.write_byte(8'h22, ack);
    wb(1'b0, STATUS_ADR, 32'h0, d);
    check("rxq", d[ST_RXQ], 1'b1);
    check("rx_irq", irq_o, 1'b1);
    u_i2c_master_model.write_byte(8'h33, ack);
    u_i2c_master_model.stop_cond();
    wb(1'b0, STATUS_ADR, 32'h0, d);
    check("ovf", d[ST_OVF], 1'b1);
    check("busy_stop", d[ST_BUSY], 1'b0);
    wb(1'b0, RX_DATA_ADR, 32'h0, d);
    check("rx0", d, 32'h11);
    wb(1'b0, STATUS_ADR, 32'h0, d);
    check("rxq_one", d[ST_RXQ], 1'b1);
    wb(1'b0, RX_DATA_ADR, 32'h0, d);
    check("rx1", d, 32'h22);
    wb(1'b0, STATUS_ADR, 32'h0, d);
    check("rxq_empty", d[ST_RXQ], 1'b0);
    check("rx_irq_off", irq_o, 1'b0);
    $display("test rx done");
  endtask
  task automatic test_mismatch_and_empty();
    u_i2c_master_model.start_cond();
    u_i2c_master_model.write_byte(8'h66, ack);
    check("foreign_ack", ack, 1'b0);
    wb(1'b0, STATUS_ADR, 32'h0, d);
    check("busy_mismatch", d[ST_BUSY], 1'b0);
    u_i2c_master_model.stop_cond();
    u_i2c_master_model.start_cond();
    u_i2c_master_model.write_byte(8'ha1, ack);
    check("empty_read_ack", ack, 1'b0);
    u_i2c_master_model.stop_cond();
    wb(1'b0, STATUS_ADR, 32'h0, d);
    check("early", d[ST_ETSTA], 1'b1);
    check("nack", d[ST_NACK], 1'b1);
    check("ufl", d[ST_UFL], 1'b1);
    wb(1'b0, STATUS_ADR, 32'h0, d);
    check("early_read", d[ST_ETSTA], 1'b0);
    $display("test mismatch and empty done");
  endtask
  task automatic test_tx();
    wr(TX_DATA_ADR, 8'h5a);
    wr(CONTROL_ADR, 8'h6f);
    wb(1'b0, STATUS_ADR, 32'h0, d);
    check("ufl_clear", d[ST_UFL], 1'b0);
    u_i2c_master_model.start_cond();
    u_i2c_master_model.write_byte(8'ha1, ack);
    check("read_ack", ack, 1'b1);
    wb(1'b0, STATUS_ADR, 32'h0, d);
    check("txq", d[ST_TXQ], 1'b1);
    check("nack_clear", d[ST_NACK], 1'b0);
    check("tx_irq", irq_o, 1'b1);
    u_i2c_master_model.read_byte(1'b0, b);
    check("tx_byte", b, 8'h5a);
    u_i2c_master_model.stop_cond();
    wb(1'b0, STATUS_ADR, 32'h0, d);
    check("txq_clear", d[ST_TXQ], 1'b0);
    check("tx_irq_off", irq_o, 1'b0);
    wr(CONTROL_ADR, 8'h17);
    u_i2c_master_model.start_cond();
    u_i2c_master_model.write_byte(8'ha0, ack);
    check("forced_nack_ack", ack, 1'b0);
    u_i2c_master_model.stop_cond();
    wb(1'b0, STATUS_ADR, 32'h0, d);
    check("early_write_bit", d[ST_ETSTA], 1'b1);
    check("forced_nack", d[ST_NACK], 1'b1);
    $display("test tx done");
  endtask
  task automatic test_gc();
    wr(CONTROL_ADR, 8'h0b);
    gcall(GC_CMD_PROG);
    wb(1'b0, STATUS_ADR, 32'h0, d);
    check("gc", d[ST_GC], 1'b1);
    check("gc_kind", d[ST_GCK+:2], GC_PROG);
    wb(1'b0, STATUS_ADR, 32'h0, d);
    check("gc_held", d[ST_GC], 1'b1);
    wr(CONTROL_ADR, 8'h8b);
    wb(1'b0, STATUS_ADR, 32'h0, d);
    check("gc_clr", d[ST_GC], 1'b0);
    check("kind_clr", d[ST_GCK+:2], GC_NONE);
    gcall(8'h55);
    wb(1'b0, STATUS_ADR, 32'h0, d);
    check("kind_alt", d[ST_GCK+:2], GC_ALT);
    wb(1'b0, RX_DATA_ADR, 32'h0, d);
    check("gc_byte", d, 32'h55);
    wr(CONTROL_ADR, 8'h8b);
    gcall(GC_CMD_RST);
    wb(1'b0, STATUS_ADR, 32'h0, d);
    check("kind_rst", d[ST_GCK+:2], GC_RST_PROG);
    wb(1'b0, CONTROL_ADR, 32'h0, d);
    check("ctrl_rst", d, {24'h0, CTRL_RESET});
    wb(1'b0, ID0_ADR, 32'h0, d);
    check("id_rst", d, 32'h0);
    $display("test general call done");
  endtask
  initial begin
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 32'h0;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'h0;
    fail_count = 0;
    checks_done = 0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    test_reset();
    test_rx();
    test_mismatch_and_empty();
    test_tx();
    test_gc();
    final_report();
  end
endmodule
`default_nettype wire
